// ---- hdl/dio_counter_handshake_config.v ----
// counter, handshake and interrupt configuration registers with wishbone slave
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
`include "dio_cfg_consts.vh"
module dio_counter_handshake_config #(
   parameter CNT_W = 8
) (
   // clock, reset, enable
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [`ADDR_W-1:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // counters
   input wire timer1_out_i,
   input wire timer2_out_i,
   input wire timer3_out_i,
   input wire extra_input_two_i,
   output wire timer1_gate_o,
   output wire timer2_gate_o,
   // handshake requests
   input wire group1_ext_request_i,
   input wire group2_ext_request_i,
   output wire group1_request_o,
   output wire group2_request_o,
   // dma terminal counts
   input wire group1_tc_i,
   input wire group2_tc_i,
   // acknowledge pulses
   input wire group1_ack_start_i,
   input wire group2_ack_start_i,
   input wire [`TIMER_SET_W-1:0] group1_timer_setting_i,
   input wire [`TIMER_SET_W-1:0] group2_timer_setting_i,
   output wire group1_ack_o,
   output wire group2_ack_o,
   // port d
   input wire portd_output_mode_i,
   input wire [`PORTD_W-1:0] portd_pins_i,
   output wire [`PORTD_W-1:0] portd_pins_o,
   output wire portd_pins_oe_o,
   // mode and interrupts
   output wire revision_compat_o,
   output wire group1_irq_o,
   output wire group2_irq_o,
   output wire irq_o
);
   reg [15:0] counter_interrupt_config;
   reg [15:0] pulse_mode_buffer_config;
   reg [`IRQ_W-1:0] irq_status;
   reg [`IRQ_W-1:0] irq_mask;
   reg timer3_q;
   reg [`IRQ_W-1:0] next_irq_status;
   reg [31:0] next_rd_data;
   wire req_active;
   wire wr_stb;
   wire [`IRQ_W-1:0] irq_event;
   wire [`IRQ_W-1:0] irq_pending;
   wire [`PORTD_W-1:0] portd_rd_data;
   wire [1:0] long_pulse;
   wire [1:0] ack_start;
   wire [1:0] ack_out;
   wire [2*`TIMER_SET_W-1:0] timer_setting;

   // byte-lane merge of a 16-bit register
   function [15:0] merge16;
      input [15:0] old_val;
      input [31:0] new_val;
      input [3:0] sel;
      begin
         merge16[7:0] = sel[0] ? new_val[7:0] : old_val[7:0];
         merge16[15:8] = sel[1] ? new_val[15:8] : old_val[15:8];
      end
   endfunction

   // address match used by both the write and the read paths
   function hit;
      input [`ADDR_W-1:0] adr;
      input [`ADDR_W-1:0] ofs;
      begin
         hit = (adr == ofs);
      end
   endfunction

   // bus handshake: one wait state, write lands on the ack edge
   assign req_active = wb_cyc_i & wb_stb_i;
   assign wr_stb = req_active & wb_we_i & wb_ack_o;

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else if (ce_i) begin
         wb_ack_o <= req_active & ~wb_ack_o;
         if (req_active & ~wb_ack_o)
            wb_dat_o <= next_rd_data;
      end
   end

   // configuration registers are write-only and read back as zero
   always @* begin
      next_rd_data = 32'h00000000;
      if (hit(wb_adr_i, `OFS_IRQ_STATUS))
         next_rd_data[`IRQ_W-1:0] = irq_status;
      else if (hit(wb_adr_i, `OFS_IRQ_MASK))
         next_rd_data[`IRQ_W-1:0] = irq_mask;
      else if (hit(wb_adr_i, `OFS_PORTD))
         next_rd_data[`PORTD_W-1:0] = portd_rd_data;
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         counter_interrupt_config <= `COUNTER_INTERRUPT_CONFIG_RESET;
         pulse_mode_buffer_config <= `PULSE_MODE_BUFFER_CONFIG_RESET;
         irq_mask <= `IRQ_RESET;
      end else if (ce_i && wr_stb) begin
         if (hit(wb_adr_i, `OFS_COUNTER_INTERRUPT_CONFIG))
            counter_interrupt_config <= merge16(counter_interrupt_config, wb_dat_i, wb_sel_i);
         if (hit(wb_adr_i, `OFS_PULSE_MODE_BUFFER_CONFIG))
            // upper bits are dropped so stray writes cannot enable anything
            pulse_mode_buffer_config <= merge16(pulse_mode_buffer_config, wb_dat_i, wb_sel_i)
               & `C4_USED_MASK;
         if (hit(wb_adr_i, `OFS_IRQ_MASK) && wb_sel_i[0])
            irq_mask <= wb_dat_i[`IRQ_W-1:0];
      end
   end

   // counter gating and request source selection
   assign timer1_gate_o = counter_interrupt_config[`C3_TIMER1_RUN_EN] & extra_input_two_i;
   assign timer2_gate_o = counter_interrupt_config[`C3_TIMER2_RUN_EN] & extra_input_two_i;
   assign group1_request_o = counter_interrupt_config[`C3_TIMER1_HS_EN] ?
      timer1_out_i : group1_ext_request_i;
   assign group2_request_o = counter_interrupt_config[`C3_TIMER2_HS_EN] ?
      timer2_out_i : group2_ext_request_i;

   // interrupt events, each gated by its enable
   assign irq_event[`IRQ_GROUP1_TC] = group1_tc_i & counter_interrupt_config[`C3_GROUP1_TC_EN];
   assign irq_event[`IRQ_GROUP2_TC] = group2_tc_i & counter_interrupt_config[`C3_GROUP2_TC_EN];
   assign irq_event[`IRQ_TIMER3] = timer3_out_i & ~timer3_q &
      counter_interrupt_config[`C3_TIMER3_IRQ_EN];

   // write-one-to-clear; an event in the clearing cycle wins
   always @* begin
      next_irq_status = irq_status;
      if (wr_stb && hit(wb_adr_i, `OFS_IRQ_STATUS) && wb_sel_i[0])
         next_irq_status = irq_status & ~wb_dat_i[`IRQ_W-1:0];
      next_irq_status = next_irq_status | irq_event;
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         irq_status <= `IRQ_RESET;
         timer3_q <= 1'b0;
      end else if (ce_i) begin
         irq_status <= next_irq_status;
         timer3_q <= timer3_out_i;
      end
   end

   assign irq_pending = irq_status & irq_mask;
   assign group1_irq_o = irq_pending[`IRQ_GROUP1_TC];
   assign group2_irq_o = irq_pending[`IRQ_GROUP2_TC] | irq_pending[`IRQ_TIMER3];
   assign irq_o = |irq_pending;

   assign revision_compat_o = pulse_mode_buffer_config[`C4_REV_COMPAT];

   // acknowledge shapers, one per group
   assign long_pulse = {pulse_mode_buffer_config[`C4_GROUP2_LONG], pulse_mode_buffer_config[`C4_GROUP1_LONG]};
   assign ack_start = {group2_ack_start_i, group1_ack_start_i};
   assign timer_setting = {group2_timer_setting_i, group1_timer_setting_i};
   assign group1_ack_o = ack_out[0];
   assign group2_ack_o = ack_out[1];

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : shaper
         ack_pulse_shaper #(
            .CNT_W(CNT_W)
         ) u_shaper (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .long_pulse_i(long_pulse[g]),
            .timer_setting_i(timer_setting[g*`TIMER_SET_W +: `TIMER_SET_W]),
            .start_i(ack_start[g]),
            .ack_o(ack_out[g])
         );
      end
   endgenerate

   // port d buffering follows the group 2 request
   portd_buffer #(
      .W(`PORTD_W)
   ) u_portd (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .double_buffer_i(pulse_mode_buffer_config[`C4_PORTD_DBL]),
      .output_mode_i(portd_output_mode_i),
      .wr_i(wr_stb & hit(wb_adr_i, `OFS_PORTD) & wb_sel_i[0]),
      .wr_data_i(wb_dat_i[`PORTD_W-1:0]),
      .rd_data_o(portd_rd_data),
      .request_i(group2_request_o),
      .pins_i(portd_pins_i),
      .pins_o(portd_pins_o),
      .pins_oe_o(portd_pins_oe_o)
   );
endmodule

// ---- pkg/dio_cfg_consts.vh ----
// constants for the counter, handshake and interrupt configuration block
`ifndef DIO_CFG_CONSTS_VH
`define DIO_CFG_CONSTS_VH
// register byte addresses
`define ADDR_W 8
`define OFS_COUNTER_INTERRUPT_CONFIG 8'h10
`define OFS_PULSE_MODE_BUFFER_CONFIG 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_MASK 8'h1C
`define OFS_PORTD 8'h20
// counter_interrupt_config fields
`define C3_TIMER3_IRQ_EN 6
`define C3_TIMER2_HS_EN 5
`define C3_TIMER1_HS_EN 4
`define C3_TIMER2_RUN_EN 3
`define C3_TIMER1_RUN_EN 2
`define C3_GROUP2_TC_EN 1
`define C3_GROUP1_TC_EN 0
`define COUNTER_INTERRUPT_CONFIG_RESET 16'h0000
// pulse_mode_buffer_config fields
`define C4_GROUP2_LONG 3
`define C4_GROUP1_LONG 2
`define C4_PORTD_DBL 1
`define C4_REV_COMPAT 0
`define C4_USED_MASK 16'h000F
`define PULSE_MODE_BUFFER_CONFIG_RESET 16'h0000
// interrupt status / mask fields
`define IRQ_W 3
`define IRQ_GROUP1_TC 0
`define IRQ_GROUP2_TC 1
`define IRQ_TIMER3 2
`define IRQ_RESET 3'h0
// timing
`define CLK_PERIOD_NS 10
`define SETTLE_STEP_NS 100
`define SETTLE_STEP_CYC (`SETTLE_STEP_NS / `CLK_PERIOD_NS)
`define ACK_WIDTH_NS 100
`define ACK_WIDTH_CYC (`ACK_WIDTH_NS / `CLK_PERIOD_NS)
`define TIMER_SET_W 3
`define PORTD_W 8
`endif

// ---- hdl/ack_pulse_shaper.v ----
// acknowledge pulse generator with leading or trailing data-settling delay
`timescale 1ns/1ps
`include "dio_cfg_consts.vh"
module ack_pulse_shaper #(
   parameter CNT_W = 8
) (
   // clock and control
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // configuration
   input wire long_pulse_i,
   input wire [`TIMER_SET_W-1:0] timer_setting_i,
   // pulse
   input wire start_i,
   output reg ack_o
);
   localparam ST_IDLE = 2'd0;
   localparam ST_DELAY = 2'd1;
   localparam ST_PULSE = 2'd2;
   reg [1:0] state;
   reg [CNT_W-1:0] count;
   wire [CNT_W-1:0] delay_cyc;
   wire [CNT_W-1:0] width_cyc;
   wire [31:0] delay_full;
   wire [31:0] width_full;
   // full-width products, cut to the counter width on purpose
   assign delay_full = timer_setting_i * `SETTLE_STEP_CYC;
   assign width_full = `ACK_WIDTH_CYC;
   assign delay_cyc = delay_full[CNT_W-1:0];
   assign width_cyc = width_full[CNT_W-1:0];
   always @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         count <= {CNT_W{1'b0}};
         ack_o <= 1'b0;
      end else if (ce_i) begin
         case (state)
            ST_IDLE: begin
               if (start_i) begin
                  if (long_pulse_i) begin
                     // delay after the leading edge stretches the pulse
                     state <= ST_PULSE;
                     ack_o <= 1'b1;
                     count <= width_cyc + delay_cyc - 1'b1;
                  end else if (delay_cyc == {CNT_W{1'b0}}) begin
                     state <= ST_PULSE;
                     ack_o <= 1'b1;
                     count <= width_cyc - 1'b1;
                  end else begin
                     state <= ST_DELAY;
                     count <= delay_cyc - 1'b1;
                  end
               end
            end
            ST_DELAY: begin
               if (count == {CNT_W{1'b0}}) begin
                  state <= ST_PULSE;
                  ack_o <= 1'b1;
                  count <= width_cyc - 1'b1;
               end else begin
                  count <= count - 1'b1;
               end
            end
            ST_PULSE: begin
               if (count == {CNT_W{1'b0}}) begin
                  state <= ST_IDLE;
                  ack_o <= 1'b0;
               end else begin
                  count <= count - 1'b1;
               end
            end
            default: begin
               state <= ST_IDLE;
               ack_o <= 1'b0;
            end
         endcase
      end
   end
endmodule

// ---- hdl/portd_buffer.v ----
// port d single or double buffer for output and input directions
`timescale 1ns/1ps
`include "dio_cfg_consts.vh"
module portd_buffer #(
   parameter W = `PORTD_W
) (
   // clock and control
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire double_buffer_i,
   input wire output_mode_i,
   // host side
   input wire wr_i,
   input wire [W-1:0] wr_data_i,
   output wire [W-1:0] rd_data_o,
   // connector side
   input wire request_i,
   input wire [W-1:0] pins_i,
   output reg [W-1:0] pins_o,
   output wire pins_oe_o
);
   reg [W-1:0] first_buf;
   reg [W-1:0] in_latch;
   reg request_q;
   wire request_rise;
   assign request_rise = request_i & ~request_q;
   assign pins_oe_o = output_mode_i;
   // transparent input unless double-buffered
   assign rd_data_o = double_buffer_i ? in_latch : pins_i;
   always @(posedge clk_i) begin
      if (rst_i) begin
         first_buf <= {W{1'b0}};
         in_latch <= {W{1'b0}};
         pins_o <= {W{1'b0}};
         request_q <= 1'b0;
      end else if (ce_i) begin
         request_q <= request_i;
         if (wr_i) begin
            first_buf <= wr_data_i;
            if (!double_buffer_i)
               pins_o <= wr_data_i;
         end
         if (double_buffer_i && request_rise) begin
            if (output_mode_i)
               pins_o <= first_buf;
            else
               in_latch <= pins_i;
         end
      end
   end
endmodule

// ---- bench/dio_peer.sv ----
// far-side peripheral: counter 3 output and group 2 terminal count pulses
`timescale 1ns/1ps
module dio_peer (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // commands from the bench
   input wire tick_i,
   input wire fire_i,
   // lines toward the block
   output logic level_o,
   output logic pulse_o
);
   // counter output toggles per tick; a terminal count follows fire one cycle later and lasts as long as fire is held
   always @(posedge clk_i) begin
      if (rst_i) begin
         level_o <= 1'b0;
         pulse_o <= 1'b0;
      end else begin
         level_o <= level_o ^ tick_i;
         pulse_o <= fire_i;
      end
   end
endmodule

// ---- bench/dio_cfg_checker.sv ----
// port assertions for the counter, handshake and interrupt configuration block
`timescale 1ns/1ps
`include "dio_cfg_consts.vh"
module dio_cfg_checker #(
   parameter CNT_W = 8
) (
   // clock, reset and bus
   input wire clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i,
   input wire [`ADDR_W-1:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   // counters, requests, acks, irqs
   input wire timer1_out_i, timer2_out_i, extra_input_two_i, timer1_gate_o, timer2_gate_o,
   input wire group1_ext_request_i, group2_ext_request_i, group1_request_o, group2_request_o,
   input wire group1_ack_o, revision_compat_o, group1_irq_o, group2_irq_o, irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence
   sequence s_ack_hi;
      group1_ack_o [*8];
   endsequence
   property p_ack_resp;
      s_req |=> wb_ack_o;
   endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
   property p_ack_pulse;
      wb_ack_o && ce_i |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
   property p_read_wo;
      (s_req ##0 (!wb_we_i && wb_adr_i == `OFS_PULSE_MODE_BUFFER_CONFIG)) |=> wb_dat_o == 32'h0;
   endproperty
   a_read_wo: assert property (p_read_wo) else $error("write-only register read nonzero");
   property p_gate;
      !extra_input_two_i |-> !timer1_gate_o && !timer2_gate_o;
   endproperty
   a_gate: assert property (p_gate) else $error("counter gate open with input low");
   property p_req1;
      timer1_out_i == group1_ext_request_i |-> group1_request_o == timer1_out_i;
   endproperty
   a_req1: assert property (p_req1) else $error("group 1 request from no source");
   property p_group2_request;
      timer2_out_i == group2_ext_request_i |-> group2_request_o == timer2_out_i;
   endproperty
   a_group2_request: assert property (p_group2_request) else $error("group 2 request from no source");
   property p_irq;
      group1_irq_o || group2_irq_o |-> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("group irq not on combined line");
   property p_rev;
      !rst_i && !(wb_ack_o && wb_we_i && wb_adr_i == `OFS_PULSE_MODE_BUFFER_CONFIG) |=> $stable(revision_compat_o);
   endproperty
   a_rev: assert property (p_rev) else $error("compat bit moved without write");
   property p_ack_w;
      $rose(group1_ack_o) |-> s_ack_hi;
   endproperty
   a_ack_w: assert property (p_ack_w) else $error("ack pulse too short");
endmodule
bind dio_counter_handshake_config dio_cfg_checker #(.CNT_W(CNT_W)) u_chk (.clk_i, .rst_i, .ce_i,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .timer1_out_i, .timer2_out_i,
   .extra_input_two_i, .timer1_gate_o, .timer2_gate_o, .group1_ext_request_i, .group2_ext_request_i,
   .group1_request_o, .group2_request_o, .group1_ack_o, .revision_compat_o, .group1_irq_o,
   .group2_irq_o, .irq_o);

// ---- bench/dio_counter_handshake_config_tb.sv ----
// self-checking bench for the configuration block
`timescale 1ns/1ps
`include "dio_cfg_consts.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module dio_counter_handshake_config_tb;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00, portd_pins_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h3;
   logic [31:0] wb_dat_i = 32'h0, q;
   logic timer1_out_i = 1'b0, timer2_out_i = 1'b0, extra_input_two_i = 1'b0, group1_ext_request_i = 1'b0;
   logic group2_ext_request_i = 1'b0, group1_tc_i = 1'b0, group1_ack_start_i = 1'b0, group2_ack_start_i = 1'b0;
   logic [2:0] group1_timer_setting_i = 3'h2, group2_timer_setting_i = 3'h0;
   logic portd_output_mode_i = 1'b0, tick = 1'b0, fire = 1'b0;
   wire [31:0] wb_dat_o;
   wire [7:0] portd_pins_o;
   wire wb_ack_o, timer3_out_i, group2_tc_i, timer1_gate_o, timer2_gate_o, group1_request_o, group2_request_o;
   wire group1_ack_o, group2_ack_o, portd_pins_oe_o, revision_compat_o, group1_irq_o, group2_irq_o, irq_o;
   int n_errors = 0, n_compared = 0, dl, wd, dl2, wd2;
   // {counter_interrupt_config[6:0], extra, t1, t2, ext1, ext2, gate1, gate2, req1, group2_request}
   logic [15:0] rows [6] = '{16'h193F, 16'h1833, 16'h093B, 16'h6192, 16'h2160, 16'h4163};
   always #5 clk_i = ~clk_i;
   dio_counter_handshake_config #(.CNT_W(8)) dut (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer1_out_i, .timer2_out_i, .timer3_out_i,
      .extra_input_two_i, .timer1_gate_o, .timer2_gate_o, .group1_ext_request_i, .group2_ext_request_i,
      .group1_request_o, .group2_request_o, .group1_tc_i, .group2_tc_i, .group1_ack_start_i,
      .group2_ack_start_i, .group1_timer_setting_i, .group2_timer_setting_i, .group1_ack_o,
      .group2_ack_o, .portd_output_mode_i, .portd_pins_i, .portd_pins_o, .portd_pins_oe_o,
      .revision_compat_o, .group1_irq_o, .group2_irq_o, .irq_o);
   dio_peer peer (.clk_i, .rst_i, .tick_i(tick), .fire_i(fire), .level_o(timer3_out_i), .pulse_o(group2_tc_i));
   task automatic test_done;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // one classic cycle; ack is sampled at the edge, so read data is taken there
   task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic wr);
      int k;
      k = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= wr;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      if (wb_ack_o !== 1'b1) begin
         n_errors++;
         test_done();
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic fire_tc;
      fire <= 1'b1;
      @(posedge clk_i);
      fire <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   task automatic measure(output int d, output int w);
      d = 0;
      w = 0;
      group1_ack_start_i <= 1'b1;
      @(posedge clk_i);
      group1_ack_start_i <= 1'b0;
      repeat (200) begin
         @(posedge clk_i);
         if (group1_ack_o === 1'b1) w++;
         else if (w == 0) d++;
      end
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int r = 0; r < 6; r++) begin
         wb(`OFS_COUNTER_INTERRUPT_CONFIG, {25'h0, rows[r][15:9]}, 1'b1);
         {extra_input_two_i, timer1_out_i, timer2_out_i, group1_ext_request_i, group2_ext_request_i} <= rows[r][8:4];
         @(posedge clk_i);
         `CHK("gate_req", rows[r][3:0], {timer1_gate_o, timer2_gate_o, group1_request_o, group2_request_o})
      end
      $display("table test done");
      wb(`OFS_IRQ_MASK, 32'h7, 1'b1);
      wb(`OFS_COUNTER_INTERRUPT_CONFIG, 32'h43, 1'b1);
      group1_tc_i <= 1'b1;
      @(posedge clk_i);
      group1_tc_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      `CHK("g1_irq", 2'b11, {group1_irq_o, irq_o})
      wb(`OFS_IRQ_STATUS, 32'h1, 1'b1);
      `CHK("irq_clear", 1'b0, irq_o)
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
      repeat (3) @(posedge clk_i);
      `CHK("t3_irq", 2'b01, {group1_irq_o, group2_irq_o})
      wb(`OFS_IRQ_MASK, 32'h0, 1'b1);
      `CHK("masked", 1'b0, irq_o)
      wb(`OFS_COUNTER_INTERRUPT_CONFIG, 32'h0, 1'b1);
      fire_tc();
      wb(`OFS_IRQ_STATUS, 32'h0, 1'b0);
      `CHK("tc2_off", 3'h4, q[2:0])
      wb(`OFS_COUNTER_INTERRUPT_CONFIG, 32'h2, 1'b1);
      fire_tc();
      wb(`OFS_IRQ_STATUS, 32'h0, 1'b0);
      `CHK("tc2_on", 3'h6, q[2:0])
      $display("interrupt test done");
      wb(`OFS_PULSE_MODE_BUFFER_CONFIG, 32'h4, 1'b1);
      measure(dl, wd);
      wb(`OFS_PULSE_MODE_BUFFER_CONFIG, 32'h0, 1'b1);
      measure(dl2, wd2);
      `CHK("long_width", 30, wd)
      `CHK("short_width", 10, wd2)
      `CHK("short_delay", dl + 20, dl2)
      group2_ack_start_i <= 1'b1;
      @(posedge clk_i);
      group2_ack_start_i <= 1'b0;
      @(posedge clk_i);
      `CHK("g2_ack_on", 1'b1, group2_ack_o)
      repeat (10) @(posedge clk_i);
      `CHK("g2_ack_off", 1'b0, group2_ack_o)
      $display("ack pulse test done");
      portd_output_mode_i <= 1'b1;
      wb(`OFS_PORTD, 32'h3C, 1'b1);
      `CHK("portd_single", 9'h13C, {portd_pins_oe_o, portd_pins_o})
      wb(`OFS_PULSE_MODE_BUFFER_CONFIG, 32'h2, 1'b1);
      wb(`OFS_PORTD, 32'hA5, 1'b1);
      `CHK("portd_held", 8'h3C, portd_pins_o)
      group2_ext_request_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK("portd_moved", 8'hA5, portd_pins_o)
      portd_output_mode_i <= 1'b0;
      group2_ext_request_i <= 1'b0;
      portd_pins_i <= 8'h5A;
      repeat (2) @(posedge clk_i);
      group2_ext_request_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      portd_pins_i <= 8'h00;
      wb(`OFS_PORTD, 32'h0, 1'b0);
      `CHK("portd_latched", 8'h5A, q[7:0])
      $display("port d test done");
      wb(`OFS_PULSE_MODE_BUFFER_CONFIG, 32'hFFF1, 1'b1);
      `CHK("rev_set", 1'b1, revision_compat_o)
      wb(`OFS_PULSE_MODE_BUFFER_CONFIG, 32'h0, 1'b0);
      `CHK("pulse_mode_buffer_config_read", 32'h0, q)
      wb(8'h40, 32'h0, 1'b0);
      `CHK("unmapped", 32'h0, q)
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      `CHK("reset", 4'h0, {revision_compat_o, irq_o, timer1_gate_o, timer2_gate_o})
      $display("register and reset test done");
      wb(`OFS_COUNTER_INTERRUPT_CONFIG, 32'h1, 1'b1);
      wb(`OFS_IRQ_MASK, 32'h1, 1'b1);
      // clock enable low must freeze the status flops
      ce_i <= 1'b0;
      group1_tc_i <= 1'b1;
      @(posedge clk_i);
      group1_tc_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      `CHK("ce_frozen", 1'b0, irq_o)
      ce_i <= 1'b1;
      group1_tc_i <= 1'b1;
      @(posedge clk_i);
      group1_tc_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      `CHK("ce_running", 1'b1, irq_o)
      $display("clock enable test done");
      test_done();
   end
endmodule
